//--- hcct_translator.sv
// Host I/O to PCI configuration-cycle translator with reset control.
// Assumes host requests and PCI completions arrive on mclk, no crossing.
`timescale 1ns/1ps
module hcct_translator (
    input  wire logic        mclk,             // Host clock
    input  wire logic        rst_b,            // Async reset, active low
    input  wire logic        clkEn,            // Freezes all state when low
    input  wire logic        ioReq,            // Host I/O request pulse
    input  wire logic        ioWrite,          // 1 write, 0 read
    input  wire logic [13:0] ioAddr,           // Dword index of I/O address
    input  wire logic [3:0]  hostUpperByteEnB, // Upper host byte enables
    input  wire logic [31:0] ioWdata,          // Host write data
    output logic             ioDone,           // Host completion pulse
    output logic      [31:0] ioRdata,          // Host read data
    output logic             pciReq,           // PCI cycle start pulse
    output logic             pciCfg,           // 1 configuration, 0 I/O
    output logic             pciWrite,         // PCI cycle direction
    output logic      [31:0] pciAddr,          // Address phase value
    output logic      [3:0]  pciCbeB,          // Data phase byte enables
    output logic      [31:0] pciWdata,         // PCI write data
    input  wire logic        pciDone,          // PCI cycle complete pulse
    input  wire logic [31:0] pciRdata,         // PCI read data
    output logic             selfDevsel,       // Bridge claims own cycle
    output logic             cpuHardResetLine, // Processor hard reset
    output logic             cpuSoftInit,      // Processor soft init
    output logic             deturbo           // Turbo select bit
);
    import hcct_pkg::*;

    // ======================================================================
    // Registers and decode
    hcct_state_t state;             // Sequencer state
    logic [31:0] cfgPointer;        // Pointer register
    logic [7:0]  turboResetControl; // Turbo and reset control register
    logic [7:0]  rstCnt;            // Reset pulse counter
    logic [31:0] encAddr;           // Encoded configuration address
    logic        encSelf;           // Cycle aims at the bridge itself
    logic        accept;            // Request taken this cycle
    logic        ptrHit;            // Pointer dword addressed
    logic        dataHit;           // Data window dword addressed
    logic        fullDword;         // All lanes enabled
    logic        trcHit;            // Reset control byte addressed alone
    logic        cfgGo;             // Configuration cycle launch
    logic [7:0]  trcNew;            // Masked write value for control byte
    logic        rstRise;           // Bit 2 rising on a control write

    assign accept    = clkEn && ioReq && (state == ST_IDLE);
    assign ptrHit    = (ioAddr == IO_PTR_IDX);
    assign dataHit   = (ioAddr == IO_DATA_IDX);
    assign fullDword = (hostUpperByteEnB == BE_FULL);
    assign trcHit    = ptrHit && (hostUpperByteEnB == BE_TRC_ONLY);
    // Any lane of the window dword counts, not only full dwords
    assign cfgGo     = dataHit && cfgPointer[PTR_EN_BIT];
    assign trcNew    = ioWdata[8*TRC_LANE +: 8] & TRC_WR_MASK;
    assign rstRise   = accept && ioWrite && trcHit
                       && !turboResetControl[TRC_RST_CPU] && trcNew[TRC_RST_CPU];

    hcct_cfg_encoder u_enc (
        .cfgPointer (cfgPointer),
        .cfgAddr    (encAddr),
        .selfHit    (encSelf)
    );

    // ======================================================================
    // Pointer register; reserved bits masked so they never read back
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfgPointer <= PTR_RESET;
        end else if (clkEn) begin
            // Only full dword writes load; partial ones other than lane 1 alone go out to PCI instead
            if (accept && ioWrite && ptrHit && fullDword) begin
                cfgPointer <= ioWdata & PTR_WR_MASK;
            end
        end
    end

    // ======================================================================
    // Turbo and reset control register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            turboResetControl <= TRC_RESET;
            deturbo           <= 1'b0;
        end else if (clkEn) begin
            // Lane 1 alone; reserved bits are dropped on the way in
            if (accept && ioWrite && trcHit) begin
                turboResetControl <= trcNew;
                deturbo           <= trcNew[TRC_TURBO];
            end
        end
    end

    // ======================================================================
    // Processor reset pulses; a second trigger mid-pulse restarts it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstCnt           <= 8'h00;
            cpuHardResetLine <= 1'b0;
            cpuSoftInit      <= 1'b0;
        end else if (clkEn) begin
            if (rstRise) begin
                if (trcNew[TRC_HARD_EN]) begin
                    // Hard reset; init rides along only in self-test mode
                    rstCnt           <= HARD_RST_CYC;
                    cpuHardResetLine <= 1'b1;
                    cpuSoftInit      <= trcNew[TRC_BIST_EN]
                                        && trcNew[TRC_INIT_EN];
                end else if (trcNew[TRC_INIT_EN]) begin
                    rstCnt           <= INIT_CYC;
                    cpuHardResetLine <= 1'b0;
                    cpuSoftInit      <= 1'b1;
                end else begin
                    // Soft reset with init disabled falls back to hard reset
                    rstCnt           <= HARD_RST_CYC;
                    cpuHardResetLine <= 1'b1;
                    cpuSoftInit      <= 1'b0;
                end
            end else if (rstCnt != 8'h00) begin
                rstCnt <= rstCnt - 8'h01;
                if (rstCnt == 8'h01) begin
                    cpuHardResetLine <= 1'b0;
                    cpuSoftInit      <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // Transaction sequencer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else if (clkEn) begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        if (ptrHit && (fullDword || trcHit)) begin
                            state <= ST_DONE;
                        end else begin
                            state <= ST_BUSY;
                        end
                    end
                end
                // Wait for the target to finish the forwarded cycle
                ST_BUSY: begin
                    if (pciDone) begin
                        state <= ST_DONE;
                    end
                end
                // One idle cycle so the host can drop its request
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // PCI cycle launch
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pciReq     <= 1'b0;
            pciCfg     <= 1'b0;
            pciWrite   <= 1'b0;
            pciAddr    <= 32'h0000_0000;
            pciCbeB    <= 4'hF;
            pciWdata   <= 32'h0000_0000;
            selfDevsel <= 1'b0;
        end else if (clkEn) begin
            // Start pulse lasts one cycle only
            pciReq <= 1'b0;
            if (accept && !(ptrHit && (fullDword || trcHit))) begin
                pciReq   <= 1'b1;
                pciWrite <= ioWrite;
                pciWdata <= ioWdata;
                pciCbeB  <= hostUpperByteEnB;
                if (cfgGo) begin
                    pciCfg     <= 1'b1;
                    pciAddr    <= encAddr;
                    selfDevsel <= encSelf;
                end else begin
                    // Plain I/O, including partial pointer accesses
                    pciCfg  <= 1'b0;
                    pciAddr <= {16'h0000, ioAddr, 2'h0};
                end
            end else if (state == ST_BUSY && pciDone) begin
                selfDevsel <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Host completion and read data
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ioDone  <= 1'b0;
            ioRdata <= 32'h0000_0000;
        end else if (clkEn) begin
            ioDone <= 1'b0;
            if (state == ST_IDLE && accept && ptrHit && fullDword) begin
                ioDone <= 1'b1;
                if (!ioWrite) begin
                    ioRdata <= cfgPointer;
                end
            // Control byte answers in lane 1
            end else if (state == ST_IDLE && accept && trcHit) begin
                ioDone <= 1'b1;
                if (!ioWrite) begin
                    ioRdata <= {16'h0000, turboResetControl, 8'h00};
                end
            end else if (state == ST_BUSY && pciDone) begin
                ioDone <= 1'b1;
                if (!pciWrite) begin
                    ioRdata <= pciRdata;
                end
            end
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Every property samples on mclk and sleeps while reset is low

    ptr_load_a: assert property (accept && ioWrite && ptrHit && fullDword
        |=> cfgPointer == ($past(ioWdata) & PTR_WR_MASK))
        else $error("pointer not loaded by full dword write");

    ptr_read_a: assert property (accept && !ioWrite && ptrHit && fullDword
        |=> ioDone && !pciReq && ioRdata == $past(cfgPointer))
        else $error("pointer read did not return pointer");

    part_fwd_a: assert property (accept && ptrHit && !fullDword && !trcHit
        |=> pciReq && !pciCfg && $stable(cfgPointer))
        else $error("partial pointer access not forwarded");

    win_plain_a: assert property (accept && dataHit && !cfgPointer[PTR_EN_BIT]
        |=> pciReq && !pciCfg)
        else $error("disabled window made config cycle");

    type0_a: assert property (accept && cfgGo && cfgPointer[BUS_MSB:BUS_LSB] == 8'h00
        |=> pciCfg && pciAddr[1:0] == TYPE0_LOW && pciAddr[10:2] == $past(cfgPointer[10:2]))
        else $error("type 0 address phase wrong");

    dev_onehot_a: assert property (pciReq && pciCfg && pciAddr[1:0] == TYPE0_LOW
        && cfgPointer[DEV_MSB:DEV_LSB] < 5'(DEV_LINES) |-> $onehot(pciAddr[31:11]))
        else $error("type 0 select not one-hot");

    type1_a: assert property (accept && cfgGo && cfgPointer[BUS_MSB:BUS_LSB] != 8'h00
        |=> pciAddr == {$past(cfgPointer[31:2]), TYPE1_LOW})
        else $error("type 1 address phase wrong");

    be_copy_a: assert property (accept && cfgGo
        |=> pciCbeB == $past(hostUpperByteEnB))
        else $error("byte enables not copied");

    self_claim_a: assert property (accept && cfgGo && encSelf
        |=> selfDevsel && pciAddr[11])
        else $error("bridge did not claim own cycle");

    soft_init_a: assert property (rstRise && !trcNew[TRC_HARD_EN] && trcNew[TRC_INIT_EN]
        |=> cpuSoftInit && !cpuHardResetLine)
        else $error("soft reset did not drive init alone");

    soft_hard_a: assert property (rstRise && !trcNew[TRC_HARD_EN] && !trcNew[TRC_INIT_EN]
        |=> cpuHardResetLine && !cpuSoftInit)
        else $error("soft reset fallback wrong");

    bist_init_a: assert property (rstRise && trcNew[TRC_HARD_EN]
        && trcNew[TRC_BIST_EN] && trcNew[TRC_INIT_EN] |=> cpuHardResetLine && cpuSoftInit)
        else $error("self-test reset missing init");

    rsvd_zero_a: assert property (cfgPointer[30:24] == 7'h00
        && cfgPointer[1:0] == 2'h0)
        else $error("pointer reserved bits set");

    // Bus number alone picks the cycle type
    cfg_type_a: assert property (accept && cfgGo
        |=> pciReq && pciCfg && pciAddr[1:0]
            == ($past(cfgPointer[BUS_MSB:BUS_LSB] == 8'h00) ? TYPE0_LOW : TYPE1_LOW))
        else $error("configuration cycle type wrong");

    // Outside reset and a new trigger, a running pulse ends only when its count runs out
    rst_hold_a: assert property (rstCnt > 8'h01 && !rstRise
        |=> $stable(cpuHardResetLine) && $stable(cpuSoftInit))
        else $error("reset pulse ended early");

    // Low clock enable holds the pointer, control, state and counter registers
    frozen_a: assert property (!clkEn
        |=> $stable(cfgPointer) && $stable(turboResetControl) && $stable(state) && $stable(rstCnt))
        else $error("state moved while clock enable low");

    hard_only_a: assert property (rstRise && trcNew[TRC_HARD_EN]
        && !(trcNew[TRC_BIST_EN] && trcNew[TRC_INIT_EN]) |=> cpuHardResetLine && !cpuSoftInit)
        else $error("hard reset drove init outside self test");

    // Main scenarios that the bench should reach
    hard_cover: cover property (rstRise && trcNew[TRC_HARD_EN]);
    bist_cover: cover property (rstRise && trcNew[TRC_HARD_EN] && trcNew[TRC_BIST_EN]);
    type0_cover: cover property (pciReq && pciCfg && pciAddr[1:0] == TYPE0_LOW);
    type1_cover: cover property (pciReq && pciCfg && pciAddr[1:0] == TYPE1_LOW);
    fwd_cover: cover property (pciReq && !pciCfg);
endmodule // hcct_translator

//--- hcct_pkg.sv
// Constants for the host configuration-cycle translator.
// Assumes one host clock, with all host and PCI handshakes on that clock.
package hcct_pkg;
    // ======================================================================
    // I/O port map
    localparam logic [15:0] IO_PTR_OFS  = 16'h0CF8;   // Pointer dword
    localparam logic [15:0] IO_TRC_OFS  = 16'h0CF9;   // Turbo/reset byte
    localparam logic [15:0] IO_DATA_OFS = 16'h0CFC;   // Data window dword
    localparam logic [13:0] IO_PTR_IDX  = IO_PTR_OFS[15:2];
    localparam logic [13:0] IO_DATA_IDX = IO_DATA_OFS[15:2];
    localparam logic [1:0]  TRC_LANE    = IO_TRC_OFS[1:0];

    // ======================================================================
    // Byte-enable patterns, active low
    localparam logic [3:0] BE_FULL     = 4'h0;        // All four lanes
    localparam logic [3:0] BE_TRC_ONLY = 4'hD;        // Lane 1 alone

    // ======================================================================
    // Pointer layout
    localparam int PTR_EN_BIT  = 31;
    localparam int BUS_MSB     = 23;
    localparam int BUS_LSB     = 16;
    localparam int DEV_MSB     = 15;
    localparam int DEV_LSB     = 11;
    localparam int DEV_LINES   = 21;                  // AD[31:11]
    localparam logic [31:0] PTR_WR_MASK = 32'h80FF_FFFC;
    localparam logic [31:0] PTR_RESET   = 32'h0000_0000;
    localparam logic [1:0]  TYPE0_LOW   = 2'h0;
    localparam logic [1:0]  TYPE1_LOW   = 2'h1;
    localparam logic [4:0]  SELF_DEV    = 5'h00;

    // ======================================================================
    // Turbo and reset control layout
    localparam int TRC_INIT_EN = 4;
    localparam int TRC_BIST_EN = 3;
    localparam int TRC_RST_CPU = 2;
    localparam int TRC_HARD_EN = 1;
    localparam int TRC_TURBO   = 0;
    localparam logic [7:0] TRC_WR_MASK = 8'h1F;        // Bits 7:5 reserved
    localparam logic [7:0] TRC_RESET   = 8'h00;

    // ======================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int HARD_RST_NS   = 1000;              // Least hard reset width
    localparam int INIT_NS       = 80;                // Least init width
    localparam logic [7:0] HARD_RST_CYC =
        8'((HARD_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] INIT_CYC =
        8'((INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ======================================================================
    // Transaction sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BUSY = 3'h2,
        ST_DONE = 3'h4
    } hcct_state_t;
endpackage

//--- hcct_cfg_encoder.sv
// Address-phase encoder for configuration cycles.
// Assumes a stable pointer value; purely combinational.
`timescale 1ns/1ps
module hcct_cfg_encoder (
    input  wire logic [31:0] cfgPointer,  // Pointer register contents
    output logic      [31:0] cfgAddr,     // Address phase value
    output logic             selfHit      // Cycle targets the bridge
);
    import hcct_pkg::*;

    // ======================================================================
    // Device decode
    logic [DEV_LINES-1:0] devSel;          // One line per device number
    logic                 busZero;         // Type 0 when set

    // One comparator per select line; devices above 20 select nothing
    genvar gi;
    generate
        for (gi = 0; gi < DEV_LINES; gi++) begin : g_sel
            assign devSel[gi] = (cfgPointer[DEV_MSB:DEV_LSB] == 5'(gi));
        end
    endgenerate

    assign busZero = (cfgPointer[BUS_MSB:BUS_LSB] == 8'h00);

    // Bridge owns device 0 on bus 0, hence AD11
    assign selfHit = busZero && (cfgPointer[DEV_MSB:DEV_LSB] == SELF_DEV);

    // ======================================================================
    // Address phase selection
    always_comb begin
        if (busZero) begin
            cfgAddr = {devSel, cfgPointer[10:2], TYPE0_LOW};
        end else begin
            cfgAddr = {cfgPointer[31:2], TYPE1_LOW};
        end
    end
endmodule // hcct_cfg_encoder

//--- hcct_pci_target.sv
// PCI configuration and I/O target model for the translator bench.
// Assumes one cycle outstanding and a one-cycle pciReq pulse on mclk.
`timescale 1ns/1ps
module hcct_pci_target (
    input  wire logic        mclk,     // Host clock
    input  wire logic        rst_b,    // Async reset, active low
    input  wire logic [3:0]  latency,  // Cycles to answer, 1 at least
    input  wire logic        pciReq,   // Cycle start pulse
    input  wire logic [31:0] pciAddr,  // Address phase value
    output logic             pciDone,  // Completion pulse
    output logic      [31:0] pciRdata  // Read data, valid with done only
);
    // ======================================================================
    // Completion timing
    localparam logic [31:0] RD_KEY = 32'hA5A5_5A5A;  // Read data is address xor key
    logic [3:0]  waitCnt;   // Cycles left before done
    logic [31:0] heldAddr;  // Address of the cycle in flight

    // Answers every target alike; claiming by the AD11 select is left to the bridge
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            waitCnt <= 4'h0;
            heldAddr <= 32'h0000_0000;
        end else if (pciReq) begin
            waitCnt <= latency;
            heldAddr <= pciAddr;
        end else if (waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
        end
    end

    // Data toggles outside done so a stale value is never mistaken for an answer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pciDone <= 1'b0;
            pciRdata <= 32'h0000_0000;
        end else if (waitCnt == 4'h1) begin
            pciDone <= 1'b1;
            pciRdata <= heldAddr ^ RD_KEY;
        end else begin
            pciDone <= 1'b0;
            pciRdata <= ~pciRdata;
        end
    end
endmodule // hcct_pci_target

//--- test_hcct_translator.sv
// Self-checking bench for the configuration-cycle translator.
// Assumes the target model above and the package constants of the design.
`timescale 1ns/1ps
module test_hcct_translator;
    import hcct_pkg::*;
    // ======================================================================
    // Signals
    logic mclk = 1'b0, rst_b = 1'b0, clkEn = 1'b1, ioReq = 1'b0, ioWrite = 1'b0;
    logic [13:0] ioAddr = 14'h0000;
    logic [3:0]  hostUpperByteEnB = 4'hF, latency = 4'h1, pciCbeB;
    logic [31:0] ioWdata = 32'h0000_0000, ioRdata, pciAddr, pciWdata, pciRdata;
    logic ioDone, pciReq, pciCfg, pciWrite, pciDone, selfDevsel;
    logic cpuHardResetLine, cpuSoftInit, deturbo;
    int errors = 0, cmp_count = 0;
    logic [1:0]  seenKind;   // 0 none, 1 plain I/O, 2 configuration
    logic [31:0] seenAddr, seenWdata, rd;
    logic [3:0]  seenCbe;
    logic        seenSelf, seenWr;
    typedef struct {logic wr; logic [13:0] idx; logic [3:0] be; logic [31:0] wd;
                    logic [1:0] kind; logic [31:0] addr; logic [31:0] rd;} hcct_row_t;
    hcct_row_t rows[14];

    always #2.5 mclk = ~mclk;

    hcct_translator DUT (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn), .ioReq(ioReq),
        .ioWrite(ioWrite), .ioAddr(ioAddr), .hostUpperByteEnB(hostUpperByteEnB),
        .ioWdata(ioWdata), .ioDone(ioDone), .ioRdata(ioRdata), .pciReq(pciReq),
        .pciCfg(pciCfg), .pciWrite(pciWrite), .pciAddr(pciAddr), .pciCbeB(pciCbeB),
        .pciWdata(pciWdata), .pciDone(pciDone), .pciRdata(pciRdata),
        .selfDevsel(selfDevsel), .cpuHardResetLine(cpuHardResetLine),
        .cpuSoftInit(cpuSoftInit), .deturbo(deturbo));
    hcct_pci_target target (.mclk(mclk), .rst_b(rst_b), .latency(latency),
        .pciReq(pciReq), .pciAddr(pciAddr), .pciDone(pciDone), .pciRdata(pciRdata));

    // Capture each PCI cycle start as it leaves the bridge
    always @(posedge mclk) if (pciReq === 1'b1) begin
        seenKind <= pciCfg ? 2'h2 : 2'h1;
        seenAddr <= pciAddr;
        seenCbe <= pciCbeB;
        seenWdata <= pciWdata;
        seenSelf <= selfDevsel;
        seenWr <= pciWrite;
    end

    // ======================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, want);
        end
    endtask

    task give_verdict;
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One host access, request held until the completion pulse is seen
    task automatic io(input logic wr, input logic [13:0] idx, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] data);
        int n;
        @(negedge mclk);
        seenKind = 2'h0;
        ioReq = 1'b1;
        ioWrite = wr;
        ioAddr = idx;
        hostUpperByteEnB = be;
        ioWdata = wd;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (ioDone !== 1'b1 && n < 100);
        check({31'h0, ioDone}, 32'h1);
        data = ioRdata;
        ioReq = 1'b0;
    endtask

    // Two control writes, then measure the processor reset pulses
    task automatic trc(input logic [7:0] first, input logic [7:0] second,
                       input int hardW, input int initW);
        int h;
        int s;
        io(1'b1, IO_PTR_IDX, BE_TRC_ONLY, {16'h0, first, 8'h00}, rd);
        io(1'b1, IO_PTR_IDX, BE_TRC_ONLY, {16'h0, second, 8'h00}, rd);
        h = 0;
        s = 0;
        repeat (260) begin
            if (cpuHardResetLine === 1'b1) h++;
            if (cpuSoftInit === 1'b1) s++;
            @(negedge mclk);
        end
        check(32'(h), 32'(hardW));
        if (initW < 0) check({31'h0, s != 0}, 32'h1);
        else check(32'(s), 32'(initW));
        io(1'b0, IO_PTR_IDX, BE_TRC_ONLY, 32'h0, rd);
        check({24'h0, rd[15:8]}, {24'h0, second & TRC_WR_MASK});
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        rows = '{
            '{1, 14'h33E, 4'h0, 32'hFFFF_FFFF, 0, 0, 0},
            '{0, 14'h33E, 4'h0, 0, 0, 0, 32'h80FF_FFFC},
            '{1, 14'h33E, 4'h0, 32'h8000_0850, 0, 0, 0},
            '{0, 14'h33F, 4'h0, 0, 2, 32'h0000_1050, 0},
            '{1, 14'h33F, 4'h2, 32'h1234_5678, 2, 32'h0000_1050, 0},
            '{1, 14'h33E, 4'h0, 32'h8001_2A4C, 0, 0, 0},
            '{0, 14'h33F, 4'h5, 0, 2, 32'h8001_2A4D, 0},
            '{1, 14'h33E, 4'h0, 32'h8000_0000, 0, 0, 0},
            '{0, 14'h33F, 4'h0, 0, 2, 32'h0000_0800, 0},
            '{1, 14'h33E, 4'h0, 32'h0000_0850, 0, 0, 0},
            '{0, 14'h33F, 4'h0, 0, 1, 32'h0000_0CFC, 0},
            '{0, 14'h33E, 4'h3, 0, 1, 32'h0000_0CF8, 0},
            '{1, 14'h33E, 4'hC, 32'hDEAD_BEEF, 1, 32'h0000_0CF8, 0},
            '{0, 14'h33E, 4'h0, 0, 0, 0, 32'h0000_0850}};
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        check({28'h0, ioDone, pciReq, cpuHardResetLine, cpuSoftInit}, 32'h0);
        check({28'h0, pciCbeB}, 32'hF);
        io(1'b0, IO_PTR_IDX, BE_FULL, 32'h0, rd);
        check(rd, PTR_RESET);
        foreach (rows[i]) begin
            latency = 4'(1 + (i % 4) * 4);
            io(rows[i].wr, rows[i].idx, rows[i].be, rows[i].wd, rd);
            check({30'h0, seenKind}, {30'h0, rows[i].kind});
            if (rows[i].kind != 2'h0) begin
                check(seenAddr, rows[i].addr);
                check({28'h0, seenCbe}, {28'h0, rows[i].be});
                check({31'h0, seenSelf}, {31'h0, rows[i].kind == 2 &&
                      rows[i].addr[1:0] == 2'h0 && rows[i].addr[11]});
            end
            if (rows[i].wr && rows[i].kind != 2'h0) check(seenWdata, rows[i].wd);
            if (rows[i].kind != 2'h0) check({31'h0, seenWr}, {31'h0, rows[i].wr});
            if (!rows[i].wr) check(rd, rows[i].kind != 2'h0 ?
                                   rows[i].addr ^ 32'hA5A5_5A5A : rows[i].rd);
        end
        trc(8'h02, 8'h06, HARD_RST_CYC, 0);
        trc(8'h00, 8'h04, HARD_RST_CYC, 0);
        trc(8'h10, 8'h14, 0, INIT_CYC);
        trc(8'h1A, 8'h1E, HARD_RST_CYC, -1);
        trc(8'h12, 8'h16, HARD_RST_CYC, 0);
        trc(8'hE1, 8'hE1, 0, 0);
        check({31'h0, deturbo}, 32'h1);
        // Frozen clock enable: a pointer write must wait untaken
        @(negedge mclk);
        clkEn = 1'b0;
        ioReq = 1'b1;
        ioWrite = 1'b1;
        ioAddr = IO_PTR_IDX;
        hostUpperByteEnB = BE_FULL;
        ioWdata = 32'h8000_0000;
        repeat (4) @(negedge mclk);
        check({31'h0, ioDone}, 32'h0);
        ioReq = 1'b0;
        clkEn = 1'b1;
        io(1'b0, IO_PTR_IDX, BE_FULL, 32'h0, rd);
        check(rd, 32'h0000_0850);
        // Reset in mid pulse cuts it and clears both registers
        io(1'b1, IO_PTR_IDX, BE_TRC_ONLY, 32'h0000_0300, rd);
        io(1'b1, IO_PTR_IDX, BE_TRC_ONLY, 32'h0000_0700, rd);
        repeat (10) @(negedge mclk);
        check({31'h0, cpuHardResetLine}, 32'h1);
        rst_b = 1'b0;
        @(negedge mclk);
        check({30'h0, cpuHardResetLine, deturbo}, 32'h0);
        rst_b = 1'b1;
        io(1'b0, IO_PTR_IDX, BE_FULL, 32'h0, rd);
        check(rd, PTR_RESET);
        io(1'b0, IO_PTR_IDX, BE_TRC_ONLY, 32'h0, rd);
        check(rd, 32'h0);
        give_verdict();
    end

    // Watchdog, far beyond the roughly 1700 cycles the sequence needs
    initial begin
        #(20000 * 5);
        errors++;
        give_verdict();
    end
endmodule // test_hcct_translator
